/* core/cws_supervisor.sv */
// Purpose: Clock source, power-on reset and watchdog for a microcontroller.
// Assumes: Supply comparators arrive as clean digital levels on hclk.
// Notes: Registers sit on an AHB-Lite slave with zero wait states.
`timescale 1ns/1ns
`include "cws_consts.svh"

// Behaviour
// - Kick rising edge restarts watchdog count.
// - Missed kick asserts reset, starts reset cycle.
// - Missed kick asserts active-low fault output.
// - Two select inputs choose eight periods.
// - Both selects high disable the watchdog.
// - Speed high full clock, low half.
// - Clock never emits shortened phases.
// - Oscillator starts only after supply rises.
// - Reset held for reset timeout after rise.
// - Supply below falling threshold forces reset.
// - Reset pin polarity and drive build option.
// - Watchdog idle in reset, restarts from zero.
// - Fault sticks until kick edge; starts clear.
// - Select pairs map 16 to 2048 ms.
module cws_supervisor
#(
  parameter cws_pkg::cws_rst_mode_t RST_MODE = cws_pkg::CWS_RST_PP_LOW,
  parameter logic [13:0] RST_CYC = 14'((`CWS_RST_TIMEOUT_NS
    + `CWS_CLK_PERIOD_NS - 1) / `CWS_CLK_PERIOD_NS),
  parameter logic [27:0] WDG_BASE_CYC =
    28'(`CWS_WDG_BASE_NS / `CWS_CLK_PERIOD_NS)
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic supply_rise_threshold,
  input wire logic supply_fall_threshold,
  input wire logic kick_input,
  input wire logic [1:0] timeout_select_a,
  input wire logic [1:0] timeout_select_b,
  input wire logic speed_select,
  output logic clock_out,
  output logic rst_out,
  output logic rst_oe_n,
  output logic fault_output_n,
  output logic fault_oe_n
);
  import cws_pkg::*;

  // ----------------------------------------
  // State and helper signals
  // ----------------------------------------
  cws_regs_t s_q; // Registered state.
  cws_regs_t s_d; // Next state.
  logic kick_edge; // Synchronised kick rising edge.
  logic [1:0] lvl_a; // Select A as 0, 1 or 2.
  logic [1:0] lvl_b; // Select B as 0, 1 or 2.
  logic [3:0] sel_idx; // Period index, 8 means disabled.
  logic wdg_dis; // Watchdog switched off by the selects.
  logic [27:0] wdg_per; // Chosen period in hclk cycles.
  logic wdg_tmo; // Period ran out without a kick.
  logic hold_done; // Reset timeout has elapsed.
  logic rst_act; // Reset asserted, before polarity mapping.
  logic [3:0] osc_lim; // Last phase count of a clock phase.
  logic osc_end; // Current clock phase ends this cycle.
  logic take; // Address phase accepted by this slave.
  logic [2:0] ev; // Interrupt events this cycle.
  logic [2:0] clr; // Write-one-to-clear of status bits.
  logic [31:0] rd_val; // Read data for the offered address.

  // ----------------------------------------
  // Select decoding
  // ----------------------------------------
  // Map a two-bit pin code to its level; the unused code 2'b11 is
  // treated as mid, the same as a floating pin.
  function automatic logic [1:0] cws_level(input logic [1:0] code);
    logic [1:0] l;
    l = 2'h1;
    if (code == 2'h0)
    begin
      l = 2'h0;
    end
    else if (code == 2'h2)
    begin
      l = 2'h2;
    end
    return l;
  endfunction : cws_level

  assign lvl_a = cws_level(timeout_select_a);
  assign lvl_b = cws_level(timeout_select_b);
  assign sel_idx = {2'h0, lvl_a} + 4'(3 * lvl_b);
  assign wdg_dis = (sel_idx == 4'h8);
  assign wdg_per = WDG_BASE_CYC << sel_idx[2:0];

  // ----------------------------------------
  // Combinational event terms
  // ----------------------------------------
  // Edge only after synchroniser.
  assign kick_edge = s_q.kick_s2 & ~s_q.kick_s3;
  // Expiry without a kick edge.
  // A count already past a period shortened by the selects expires at
  // once, rather than running on until the counter wraps.
  assign wdg_tmo = (s_q.st == CWS_RUN) && !wdg_dis && !kick_edge
    && (s_q.wdg_cnt >= wdg_per - 28'h1);
  assign hold_done = (s_q.hold_cnt == RST_CYC - 14'h1);
  assign rst_act = (s_q.st != CWS_RUN) | supply_fall_threshold;
  assign osc_lim = s_q.spd_full ? 4'(`CWS_OSC_HALF_CYC - 1)
    : 4'(2 * `CWS_OSC_HALF_CYC - 1);
  assign osc_end = s_q.osc_on && (s_q.ph == osc_lim);
  assign take = hsel && htrans[1] && hready;
  assign ev[`CWS_IRQ_TMO] = wdg_tmo && !supply_fall_threshold;
  assign ev[`CWS_IRQ_BROWN] = (s_q.st != CWS_OFF)
    && supply_fall_threshold;
  assign ev[`CWS_IRQ_REL] = (s_q.st == CWS_HOLD) && hold_done
    && !supply_fall_threshold;
  assign clr = (s_q.ap_wr && s_q.ap_off == `CWS_OFF_IRQ_STAT)
    ? hwdata[2:0] : 3'h0;

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    rd_val = 32'h0;
    unique case (haddr[7:0])
      `CWS_OFF_STATUS:
      begin
        rd_val[`CWS_ST_RST] = rst_act;
        rd_val[`CWS_ST_FAULT] = s_q.fault;
        rd_val[`CWS_ST_OSC] = s_q.osc_on;
        rd_val[`CWS_ST_WDG_DIS] = wdg_dis;
        rd_val[5:4] = s_q.st;
      end
      `CWS_OFF_IRQ_STAT:
      begin
        rd_val[2:0] = s_q.irq_stat;
      end
      `CWS_OFF_IRQ_MASK:
      begin
        rd_val[2:0] = s_q.irq_mask;
      end
      default:
      begin
        rd_val = 32'h0;
      end
    endcase
    if (haddr[31:8] != 24'h0)
    begin
      rd_val = 32'h0;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // One process builds the whole next state from the current one.
  always_comb
  begin
    s_d = s_q;
    s_d.kick_s1 = kick_input;
    s_d.kick_s2 = s_q.kick_s1;
    s_d.kick_s3 = s_q.kick_s2;

    // Reset sequence.
    unique case (s_q.st)
      CWS_OFF:
      begin
        s_d.hold_cnt = 14'h0;
        if (supply_rise_threshold && !supply_fall_threshold)
        begin
          s_d.st = CWS_HOLD;
        end
      end
      CWS_HOLD:
      begin
        if (supply_fall_threshold)
        begin
          s_d.st = CWS_OFF;
        end
        else if (hold_done)
        begin
          s_d.st = CWS_RUN;
          s_d.hold_cnt = 14'h0;
        end
        else
        begin
          s_d.hold_cnt = s_q.hold_cnt + 14'h1;
        end
      end
      CWS_RUN:
      begin
        if (supply_fall_threshold)
        begin
          s_d.st = CWS_OFF;
        end
        else if (wdg_tmo)
        begin
          s_d.st = CWS_HOLD;
          s_d.hold_cnt = 14'h0;
        end
      end
      default:
      begin
        // A corrupted code falls back to the safe, reset state.
        s_d.st = CWS_OFF;
        s_d.hold_cnt = 14'h0;
      end
    endcase

    // Counter idle and cleared in reset.
    if (s_q.st != CWS_RUN || wdg_dis || wdg_tmo)
    begin
      s_d.wdg_cnt = 28'h0;
    end
    else if (kick_edge)
    begin
      s_d.wdg_cnt = 28'h0;
    end
    else
    begin
      s_d.wdg_cnt = s_q.wdg_cnt + 28'h1;
    end

    if (wdg_tmo)
    begin
      s_d.fault = 1'b1;
    end
    else if (kick_edge)
    begin
      s_d.fault = 1'b0;
    end

    // Clock generator; phases only end at their full count, so a
    // speed change or a stop never leaves a short pulse behind.
    if (!s_q.osc_on)
    begin
      s_d.ph = 4'h0;
      s_d.clk = 1'b0;
      s_d.spd_full = speed_select;
      if (supply_rise_threshold && !supply_fall_threshold)
      begin
        s_d.osc_on = 1'b1;
      end
    end
    else if (osc_end)
    begin
      s_d.ph = 4'h0;
      s_d.clk = ~s_q.clk;
      s_d.spd_full = speed_select;
      if (s_q.clk && supply_fall_threshold)
      begin
        s_d.osc_on = 1'b0;
      end
    end
    else
    begin
      s_d.ph = s_q.ph + 4'h1;
    end

    // Interrupt status: a new event wins over a clear.
    s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
    if (s_q.ap_wr && s_q.ap_off == `CWS_OFF_IRQ_MASK)
    begin
      s_d.irq_mask = hwdata[2:0];
    end

    // Bus: latch the address phase, prepare read data for the
    // data phase so hrdata comes straight from a flip-flop.
    s_d.ap_wr = take && hwrite;
    if (take)
    begin
      s_d.ap_off = (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
      if (!hwrite)
      begin
        s_d.rdata = rd_val;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // All flip-flops reset to constants; the fault starts released.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q <= '{st: CWS_OFF, irq_mask: `CWS_IRQ_MASK_RST, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(s_q.irq_stat & s_q.irq_mask);
  assign clock_out = s_q.clk;
  assign fault_output_n = 1'b0;
  assign fault_oe_n = ~s_q.fault;

  // Reset pin mapping; open drain only ever pulls low.
  always_comb
  begin
    unique case (RST_MODE)
      CWS_RST_PP_HIGH:
      begin
        rst_out = rst_act;
        rst_oe_n = 1'b0;
      end
      CWS_RST_PP_LOW:
      begin
        rst_out = ~rst_act;
        rst_oe_n = 1'b0;
      end
      default:
      begin
        rst_out = 1'b0;
        rst_oe_n = ~rst_act;
      end
    endcase
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cws_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence cws_expiry;
    s_q.st == CWS_RUN && wdg_tmo && !supply_fall_threshold;
  endsequence

  sequence cws_reset_cycle;
    s_q.st == CWS_HOLD && s_q.hold_cnt == 14'h0 && rst_act;
  endsequence

  a_kick_restart: assert property (
    s_q.st == CWS_RUN && kick_edge && !supply_fall_threshold
    |=> s_q.wdg_cnt == 28'h0)
    else $error("kick edge did not restart the count");

  a_expiry_reset: assert property (
    cws_expiry |=> cws_reset_cycle)
    else $error("expiry did not start a reset cycle");

  a_fault_on_expiry: assert property (
    cws_expiry |=> s_q.fault && !fault_oe_n && !fault_output_n)
    else $error("expiry did not pull the fault output");

  a_count_bound: assert property (
    s_q.st == CWS_RUN && !wdg_dis && $stable(sel_idx)
    |-> s_q.wdg_cnt < wdg_per)
    else $error("watchdog count passed the period");

  a_disabled_runs: assert property (
    s_q.st == CWS_RUN && wdg_dis && !supply_fall_threshold
    |=> s_q.st == CWS_RUN && !$rose(s_q.fault))
    else $error("disabled watchdog acted");

  a_phase_length: assert property (
    s_q.osc_on && $past(s_q.osc_on) && $changed(s_q.clk)
    |-> $past(s_q.ph) == $past(osc_lim))
    else $error("clock phase ended early");

  a_speed_full: assert property (
    osc_end && speed_select |=> osc_lim == 4'h4)
    else $error("full speed phase length wrong");

  a_osc_stopped: assert property (
    !s_q.osc_on && !supply_rise_threshold |=> !clock_out)
    else $error("clock ran before supply rise");

  a_hold_release: assert property (
    s_q.st == CWS_HOLD && s_q.hold_cnt == RST_CYC - 14'h1
    && !supply_fall_threshold |=> s_q.st == CWS_RUN
    && rst_act == supply_fall_threshold)
    else $error("reset not released after timeout");

  a_brownout_reset: assert property (
    supply_fall_threshold |-> rst_act ##1 s_q.st == CWS_OFF)
    else $error("brownout did not hold reset");

  a_wdg_idle: assert property (
    s_q.st != CWS_RUN |=> s_q.wdg_cnt == 28'h0)
    else $error("watchdog counted during reset");

  a_fault_sticky: assert property (
    s_q.fault && !kick_edge |=> s_q.fault)
    else $error("fault released without a kick");

endmodule : cws_supervisor

/* core/cws_consts.svh */
// Purpose: Offsets, field positions and timing figures of the supervisor.
// Assumes: Included by bare name from the supervisor design file.
// Notes: Times are in their own unit; reset and watchdog cycle counts are derived in code.
`ifndef CWS_CONSTS_SVH
`define CWS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CWS_OFF_STATUS 8'h00
`define CWS_OFF_IRQ_STAT 8'h04
`define CWS_OFF_IRQ_MASK 8'h08

// ----------------------------------------
// Field positions and interrupt mask reset value
// ----------------------------------------
`define CWS_ST_RST 0
`define CWS_ST_FAULT 1
`define CWS_ST_OSC 2
`define CWS_ST_WDG_DIS 3
`define CWS_IRQ_TMO 0
`define CWS_IRQ_BROWN 1
`define CWS_IRQ_REL 2
`define CWS_IRQ_MASK_RST 3'h0

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define CWS_CLK_PERIOD_NS 10
`define CWS_RST_TIMEOUT_NS 135000
`define CWS_WDG_BASE_NS 16000000
`define CWS_OSC_HALF_CYC 5

`endif

/* core/cws_pkg.sv */
// Purpose: Types shared by the clock and watchdog supervisor.
// Assumes: Nothing beyond the constants header.
// Notes: All state of the design travels in one packed struct.
package cws_pkg;

  // Supervisor reset sequence states.
  typedef enum logic [1:0]
  {
    CWS_OFF = 2'b00,
    CWS_HOLD = 2'b01,
    CWS_RUN = 2'b10
  } cws_state_t;

  // Build choice for the reset pin polarity and drive.
  typedef enum logic [1:0]
  {
    CWS_RST_PP_HIGH = 2'b00,
    CWS_RST_PP_LOW = 2'b01,
    CWS_RST_OD_LOW = 2'b10
  } cws_rst_mode_t;

  // Every flip-flop of the supervisor.
  typedef struct packed {
    cws_state_t st;
    logic [13:0] hold_cnt;
    logic [27:0] wdg_cnt;
    logic kick_s1;
    logic kick_s2;
    logic kick_s3;
    logic fault;
    logic osc_on;
    logic clk;
    logic [3:0] ph;
    logic spd_full;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic ap_wr;
    logic [7:0] ap_off;
    logic [31:0] rdata;
  } cws_regs_t;

endpackage : cws_pkg

/* tb/cws_mcu_model.sv */
// Purpose: Microcontroller beside the supervisor: takes clock and reset.
// Assumes: Kicks only while its reset is released, as real firmware does.
// Notes: A kick_gap of zero stops kicking; min_phase is the shortest phase.
`timescale 1ns/1ns
module cws_mcu_model
(
  input wire logic hclk,
  input wire logic clock_out,
  input wire logic rst_out,
  input wire logic [15:0] kick_gap,
  output logic kick_input,
  output logic [7:0] min_phase
);
  logic [15:0] kcnt = 16'h0; // Cycles since the last kick began.
  logic [7:0] run = 8'h0; // Length of the clock phase in progress.
  logic last_clk = 1'b0; // Clock level seen at the previous edge.
  logic seen = 1'b0; // The first phase is partial, so it is skipped.
  logic kick_q = 1'b0; // Kick level, written by one process only.
  logic [7:0] min_q = 8'hFF; // Shortest phase seen so far.
  assign kick_input = kick_q;
  assign min_phase = min_q;

  always @(posedge hclk)
  begin
    if (rst_out !== 1'b1 || kick_gap == 16'h0)
    begin
      kcnt <= 16'h0;
      kick_q <= 1'b0;
    end
    else
    begin
      kcnt <= (kcnt >= kick_gap - 16'h1) ? 16'h0 : kcnt + 16'h1;
      kick_q <= (kcnt < 16'h4);
    end
  end

  // Phase lengths are kept so that a shortened phase shows up later.
  always @(posedge hclk)
  begin
    last_clk <= clock_out;
    // Unknown levels before reset count as low, so no false phase.
    if ((clock_out === 1'b1) != (last_clk === 1'b1))
    begin
      run <= 8'h1;
      seen <= 1'b1;
      if (seen && run < min_q)
        min_q <= run;
    end
    else if (run != 8'hFF)
      run <= run + 8'h1;
  end
endmodule : cws_mcu_model

/* tb/test_cws_supervisor.sv */
// Purpose: Self-checking bench of the clock and watchdog supervisor.
// Assumes: Short counts: reset hold 20 cycles, watchdog base 50 cycles.
// Notes: Reset pin in its default active-low push-pull build.
`timescale 1ns/1ns
`include "cws_consts.svh"
module test_cws_supervisor;
  import cws_pkg::*;
  localparam int RST_C = 20;
  localparam int WDG_C = 50;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, irq, kick_input, clock_out, rst_out;
  logic rst_oe_n, fault_output_n, fault_oe_n;
  logic rise = 1'b0; // Supply above rising threshold.
  logic fall = 1'b0; // Supply below falling threshold.
  logic [1:0] sel_a = 2'h0;
  logic [1:0] sel_b = 2'h0;
  logic speed = 1'b1;
  logic [15:0] kick_gap = 16'h0;
  logic [7:0] min_phase;
  int n_errors = 0;
  int n_compared = 0;

  always #5 hclk = ~hclk;

  cws_supervisor #(.RST_CYC(14'(RST_C)), .WDG_BASE_CYC(28'(WDG_C)))
  u_cws_supervisor
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .supply_rise_threshold(rise),
    .supply_fall_threshold(fall), .kick_input(kick_input),
    .timeout_select_a(sel_a), .timeout_select_b(sel_b),
    .speed_select(speed), .clock_out(clock_out), .rst_out(rst_out),
    .rst_oe_n(rst_oe_n), .fault_output_n(fault_output_n),
    .fault_oe_n(fault_oe_n)
  );

  // Two more builds share every input but the tied-off bus, to see the other reset pin options.
  logic od_rst_out, od_rst_oe_n, hi_rst_out, hi_rst_oe_n;

  cws_supervisor #(.RST_MODE(CWS_RST_OD_LOW), .RST_CYC(14'(RST_C)),
    .WDG_BASE_CYC(28'(WDG_C)))
  u_cws_supervisor_od
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(32'h0),
    .htrans(2'h0), .hwrite(1'b0), .hsize(3'h2), .hwdata(32'h0),
    .hready(1'b1), .hrdata(), .hreadyout(), .hresp(), .irq(),
    .supply_rise_threshold(rise), .supply_fall_threshold(fall),
    .kick_input(kick_input), .timeout_select_a(sel_a),
    .timeout_select_b(sel_b), .speed_select(speed), .clock_out(),
    .rst_out(od_rst_out), .rst_oe_n(od_rst_oe_n), .fault_output_n(),
    .fault_oe_n()
  );

  cws_supervisor #(.RST_MODE(CWS_RST_PP_HIGH), .RST_CYC(14'(RST_C)),
    .WDG_BASE_CYC(28'(WDG_C)))
  u_cws_supervisor_hi
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(32'h0),
    .htrans(2'h0), .hwrite(1'b0), .hsize(3'h2), .hwdata(32'h0),
    .hready(1'b1), .hrdata(), .hreadyout(), .hresp(), .irq(),
    .supply_rise_threshold(rise), .supply_fall_threshold(fall),
    .kick_input(kick_input), .timeout_select_a(sel_a),
    .timeout_select_b(sel_b), .speed_select(speed), .clock_out(),
    .rst_out(hi_rst_out), .rst_oe_n(hi_rst_oe_n), .fault_output_n(),
    .fault_oe_n()
  );

  cws_mcu_model u_cws_mcu_model
  (
    .hclk(hclk), .clock_out(clock_out), .rst_out(rst_out),
    .kick_gap(kick_gap), .kick_input(kick_input), .min_phase(min_phase)
  );

  task automatic end_of_test;
    $display("COUNTS compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // A limit that runs out is a mismatch and ends the run at once.
  task automatic give_up(input string what);
    chk(what, 32'h0, 32'h1);
    end_of_test();
  endtask : give_up

  task automatic ahb_wait;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
      if (n > 16)
        give_up("hready_wait");
    end
    while (hreadyout !== 1'b1);
  endtask : ahb_wait

  // One single word transfer; read data is taken at the data phase end.
  task automatic ahb(input logic wr, input logic [7:0] off,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, off};
    htrans <= 2'b10;
    hwrite <= wr;
    ahb_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    ahb_wait();
    rd = hrdata;
    // Let the write land before the caller looks at what it changed.
    #1;
  endtask : ahb

  // Counts cycles, sampled just after each edge, until reset reads want.
  task automatic wait_rst(input logic want, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge hclk);
      #1;
      n++;
      if (n > lim)
        give_up("reset_wait");
    end
    while ((rst_out === 1'b0) !== want);
  endtask : wait_rst

  task automatic wait_clk(input logic v, output int n);
    n = 0;
    while (clock_out !== v)
    begin
      @(posedge hclk);
      n++;
      if (n > 100)
        give_up("clock_wait");
    end
  endtask : wait_clk

  // One full cycle settles the speed change, the next one is measured.
  task automatic clk_phase(input int exp);
    int n;
    wait_clk(1'b0, n);
    wait_clk(1'b1, n);
    wait_clk(1'b0, n);
    wait_clk(1'b1, n);
    wait_clk(1'b0, n);
    chk("clock_high", exp, n);
    wait_clk(1'b1, n);
    chk("clock_low", exp, n);
  endtask : clk_phase

  task automatic t_power_up;
    logic [31:0] v;
    int n;
    n = 0;
    repeat (30) @(posedge hclk) n += clock_out;
    chk("clock_before_rise", 0, n);
    chk("rst_before_rise", 1'b0, rst_out);
    chk("rst_oe_n", 1'b0, rst_oe_n);
    chk("od_rst_out", 1'b0, od_rst_out);
    chk("od_rst_oe_n", 1'b0, od_rst_oe_n);
    chk("hi_rst_out", 1'b1, hi_rst_out);
    chk("hi_rst_oe_n", 1'b0, hi_rst_oe_n);
    ahb(1'b0, `CWS_OFF_STATUS, 32'h0, v);
    chk("status_reset", 32'h1, v);
    ahb(1'b0, `CWS_OFF_IRQ_STAT, 32'h0, v);
    chk("irq_stat_reset", 32'h0, v);
    ahb(1'b0, `CWS_OFF_IRQ_MASK, 32'h0, v);
    chk("irq_mask_reset", 32'h0, v);
    chk("hresp", 1'b0, hresp);
    chk("fault_at_power_up", 1'b1, fault_oe_n);
    @(posedge hclk);
    rise <= 1'b1;
    wait_rst(1'b0, 100, n);
    chk("release_delay", RST_C + 1, n);
    chk("od_released", 1'b1, od_rst_oe_n);
    chk("hi_released", 1'b0, hi_rst_out);
    $display("TEST power_up done");
  endtask : t_power_up

  task automatic t_clock;
    clk_phase(5);
    @(posedge hclk);
    speed <= 1'b0;
    clk_phase(10);
    @(posedge hclk);
    speed <= 1'b1;
    clk_phase(5);
    $display("TEST clock done");
  endtask : t_clock

  task automatic t_kick_ok;
    int n;
    n = 0;
    @(posedge hclk);
    kick_gap <= 16'd30;
    // An expiry already under way may still finish; let it clear first.
    repeat (80) @(posedge hclk);
    repeat (400) @(posedge hclk) n += (rst_out === 1'b0);
    chk("rst_while_kicked", 0, n);
    chk("fault_while_kicked", 1'b1, fault_oe_n);
    $display("TEST kick_ok done");
  endtask : t_kick_ok

  task automatic t_expiry;
    int n;
    @(posedge hclk);
    kick_gap <= 16'h0;
    wait_rst(1'b1, 500, n);
    wait_rst(1'b0, 100, n);
    wait_rst(1'b1, 500, n);
    chk("expiry_delay", WDG_C, n);
    chk("fault_oe_n_set", 1'b0, fault_oe_n);
    chk("fault_level", 1'b0, fault_output_n);
    wait_rst(1'b0, 100, n);
    chk("reset_cycle", RST_C, n);
    chk("fault_held", 1'b0, fault_oe_n);
    @(posedge hclk);
    kick_gap <= 16'd30;
    n = 0;
    while (fault_oe_n !== 1'b1)
    begin
      @(posedge hclk);
      n++;
      if (n > 40)
        give_up("fault_clear_wait");
    end
    $display("TEST expiry done");
  endtask : t_expiry

  task automatic t_irq;
    logic [31:0] v;
    ahb(1'b0, `CWS_OFF_IRQ_STAT, 32'h0, v);
    chk("irq_stat_events", 32'h5, v);
    chk("irq_masked", 1'b0, irq);
    ahb(1'b1, `CWS_OFF_IRQ_MASK, 32'h1, v);
    chk("irq_unmasked", 1'b1, irq);
    ahb(1'b1, `CWS_OFF_IRQ_STAT, 32'h1, v);
    chk("irq_cleared", 1'b0, irq);
    ahb(1'b0, `CWS_OFF_IRQ_STAT, 32'h0, v);
    chk("irq_stat_w1c", 32'h4, v);
    ahb(1'b1, 8'h0C, 32'h7, v);
    ahb(1'b0, 8'h0C, 32'h0, v);
    chk("unmapped_read", 32'h0, v);
    ahb(1'b0, `CWS_OFF_IRQ_MASK, 32'h0, v);
    chk("mask_kept", 32'h1, v);
    ahb(1'b1, `CWS_OFF_IRQ_STAT, 32'h7, v);
    $display("TEST irq done");
  endtask : t_irq

  // Entries 0 to 7 walk the table, entry 8 reads code 11 as mid.
  task automatic t_periods;
    int n;
    @(posedge hclk);
    kick_gap <= 16'h0;
    wait_rst(1'b1, 500, n);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge hclk);
      sel_a <= (i == 8) ? 2'b11 : 2'(i % 3);
      sel_b <= (i == 8) ? 2'b00 : 2'(i / 3);
      wait_rst(1'b0, 100, n);
      wait_rst(1'b1, 7000, n);
      chk("period", (i == 8) ? WDG_C * 2 : WDG_C << i, n);
    end
    @(posedge hclk);
    sel_a <= 2'b10;
    sel_b <= 2'b10;
    wait_rst(1'b0, 100, n);
    n = 0;
    repeat (13000) @(posedge hclk) n += (rst_out === 1'b0);
    chk("disabled_resets", 0, n);
    $display("TEST periods done");
  endtask : t_periods

  task automatic t_brownout;
    logic [31:0] v;
    int n;
    @(posedge hclk);
    fall <= 1'b1;
    #1;
    chk("rst_on_fall", 1'b0, rst_out);
    chk("od_on_fall", 1'b0, od_rst_oe_n);
    chk("hi_on_fall", 1'b1, hi_rst_out);
    repeat (30) @(posedge hclk);
    n = 0;
    repeat (30) @(posedge hclk) n += clock_out;
    chk("clock_stopped", 0, n);
    ahb(1'b0, `CWS_OFF_IRQ_STAT, 32'h0, v);
    chk("brownout_event", 32'h2, v & 32'h2);
    @(posedge hclk);
    fall <= 1'b0;
    wait_rst(1'b0, 100, n);
    chk("release_after_fall", RST_C + 1, n);
    $display("TEST brownout done");
  endtask : t_brownout

  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_power_up();
    t_clock();
    t_kick_ok();
    t_expiry();
    t_irq();
    t_periods();
    t_brownout();
    chk("min_phase", 32'd5, {24'h0, min_phase});
    end_of_test();
  end
endmodule : test_cws_supervisor
